// ===== common/pss_pkg.sv
package pss_pkg;
    localparam int NSEG = 4;
    localparam int NREF = 6;
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_NS = 1_000_000;
    localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
    localparam int MIN_PER_HOUR = 60;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] START_SP_OFS = 8'h08;
    localparam logic [7:0] DEV_BAND_OFS = 8'h0c;
    localparam logic [7:0] DEV_GRP_OFS = 8'h10;
    localparam logic [7:0] NREF_OFS = 8'h14;
    localparam logic [7:0] WAIT_ZONE_OFS = 8'h18;
    localparam logic [7:0] WAIT_TIME_OFS = 8'h1c;
    localparam logic [7:0] JUNC_OFS = 8'h20;
    localparam logic [7:0] TEV_ON_OFS = 8'h24;
    localparam logic [7:0] NSEG_OFS = 8'h28;
    localparam logic [7:0] REF_BASE = 8'h40;
    localparam logic [7:0] TGT_BASE = 8'h60;
    localparam logic [7:0] TIME_BASE = 8'h70;
    localparam logic [7:0] RAMP_BASE = 8'h80;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_CANCEL_BIT = 1;
    localparam int CTRL_STC_LSB = 2;
    localparam int CTRL_METHOD_BIT = 4;
    localparam int CTRL_WAIT_BIT = 5;
    localparam int CTRL_PIDM_LSB = 6;
    localparam int CTRL_TMU_BIT = 8;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] NSEG_RST = 16'h0001;
    localparam logic [15:0] NREF_RST = 16'h0000;
    localparam logic [15:0] DEV_GRP_RST = 16'h0001;
    localparam logic [1:0] STC_ZERO = 2'h0;
    localparam logic [1:0] STC_RAMP = 2'h1;
    localparam logic [1:0] STC_TIME = 2'h2;
    localparam logic [1:0] PIDM_ZONE = 2'h0;
    localparam logic [1:0] PIDM_DEV = 2'h1;
    localparam logic [1:0] PIDM_BOTH = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [3:0] {
        PSS_IDLE = 4'h1,
        PSS_RUN = 4'h2,
        PSS_WAIT = 4'h4,
        PSS_HOLD = 4'h8
    } pss_state_t;
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } pss_axi_req_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pss_axi_rsp_t;
endpackage

// ===== rtl/pss_seq.sv
`timescale 1ns/1ns
`default_nettype none
module pss_seq #(
    parameter int unsigned TICK_CYCLES = pss_pkg::TICK_CYC
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // register bus
    input wire pss_pkg::pss_axi_req_t axi_req_i,
    output pss_pkg::pss_axi_rsp_t axi_rsp_o,
    // pins
    input wire logic [15:0] pv_i,
    input wire logic hold_cancel_i,
    // control loop side
    input wire logic [15:0] ctrl_calc_i,
    input wire logic [7:0] event_calc_i,
    output logic [15:0] sp_o,
    output logic [2:0] pid_group_o,
    output logic [15:0] ctrl_out_o,
    output logic [7:0] event_o,
    output logic time_event_o,
    output logic wait_o
);
    typedef struct packed {
        logic [15:0] pv_m;
        logic [15:0] pv;
        logic cn_m;
        logic cn;
        logic aw_full;
        logic [7:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0] ctrl;
        logic [15:0] start_sp;
        logic [15:0] dev_band;
        logic [15:0] dev_grp;
        logic [15:0] nref;
        logic [15:0] wait_zone;
        logic [15:0] wait_time;
        logic [15:0] junc;
        logic [15:0] tev_on;
        logic [15:0] nseg;
        logic [pss_pkg::NREF-1:0][15:0] refs;
        logic [pss_pkg::NSEG-1:0][15:0] tgt;
        logic [pss_pkg::NSEG-1:0][15:0] tim;
        logic [pss_pkg::NSEG-1:0][15:0] ramp;
        pss_pkg::pss_state_t state;
        logic [31:0] tick_cnt;
        logic [1:0] seg;
        logic ramp_mode;
        logic [15:0] rate;
        logic [15:0] seg_start;
        logic [15:0] elapsed;
        logic [15:0] wait_cnt;
        logic [15:0] total;
        logic [15:0] sp;
        logic [2:0] deviation_pid_group_number;
        logic [15:0] ctrl_out;
        logic [7:0] events;
        logic tev;
    } pss_st_t;

    pss_st_t s_q;
    pss_st_t s_d;
    logic [1:0] rst_sync_q;
    logic rst_n;

    function automatic logic [16:0] adiff(logic [15:0] a, logic [15:0] b);
        logic [16:0] d;
        d = {a[15], a} - {b[15], b};
        return d[16] ? 17'(-d) : d;
    endfunction

    function automatic logic [15:0] merge(logic [15:0] o, logic [31:0] n,
                                          logic [3:0] st);
        logic [15:0] r;
        r = o;
        if (st[0])
            r[7:0] = n[7:0];
        if (st[1])
            r[15:8] = n[15:8];
        return r;
    endfunction

    // reset is released through two flops, asserted at once
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    always_comb
    begin
        logic [7:0] a;
        logic [16:0] dev;
        logic [2:0] zgrp;
        logic tick;
        logic seg_end;
        logic in_band;
        logic [1:0] program_start_selector;
        logic [15:0] nxt;
        logic signed [63:0] span;
        logic [31:0] tick_len;
        logic [2:0] ridx;
        logic [1:0] sidx;
        logic meth;
        a = 8'h00;
        dev = 17'h00000;
        zgrp = 3'h1;
        tick = 1'b0;
        seg_end = 1'b0;
        in_band = 1'b0;
        program_start_selector = s_q.ctrl[pss_pkg::CTRL_STC_LSB +: 2];
        nxt = 16'h0000;
        span = 64'sh0;
        tick_len = 32'h0;
        ridx = 3'h0;
        sidx = 2'h0;
        meth = s_q.ctrl[pss_pkg::CTRL_METHOD_BIT];
        s_d = s_q;
        // pins cross into the clock domain through two flops
        s_d.pv_m = pv_i;
        s_d.pv = s_q.pv_m;
        s_d.cn_m = hold_cancel_i;
        s_d.cn = s_q.cn_m;
        s_d.ctrl[pss_pkg::CTRL_RUN_BIT] = 1'b0;
        s_d.ctrl[pss_pkg::CTRL_CANCEL_BIT] = 1'b0;

        // write channel: address and data taken in either order
        if (axi_req_i.awvalid && !s_q.aw_full && !s_q.bvalid)
        begin
            s_d.aw_full = 1'b1;
            s_d.aw_addr = axi_req_i.awaddr;
        end
        if (axi_req_i.wvalid && !s_q.w_full && !s_q.bvalid)
        begin
            s_d.w_full = 1'b1;
            s_d.w_data = axi_req_i.wdata;
            s_d.w_strb = axi_req_i.wstrb;
        end
        if (s_q.bvalid && axi_req_i.bready)
            s_d.bvalid = 1'b0;
        if (s_q.aw_full && s_q.w_full && !s_q.bvalid)
        begin
            a = s_q.aw_addr;
            s_d.aw_full = 1'b0;
            s_d.w_full = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = pss_pkg::RESP_OKAY;
            ridx = 3'((a - pss_pkg::REF_BASE) >> 2);
            sidx = 2'(a >> 2);
            case (a)
                pss_pkg::CTRL_OFS:
                    s_d.ctrl = merge(s_d.ctrl, s_q.w_data, s_q.w_strb);
                pss_pkg::START_SP_OFS:
                    s_d.start_sp = merge(s_q.start_sp, s_q.w_data, s_q.w_strb);
                pss_pkg::DEV_BAND_OFS:
                    s_d.dev_band = merge(s_q.dev_band, s_q.w_data, s_q.w_strb);
                pss_pkg::DEV_GRP_OFS:
                    s_d.dev_grp = merge(s_q.dev_grp, s_q.w_data, s_q.w_strb);
                pss_pkg::NREF_OFS:
                    s_d.nref = merge(s_q.nref, s_q.w_data, s_q.w_strb);
                pss_pkg::WAIT_ZONE_OFS:
                    s_d.wait_zone = merge(s_q.wait_zone, s_q.w_data, s_q.w_strb);
                pss_pkg::WAIT_TIME_OFS:
                    s_d.wait_time = merge(s_q.wait_time, s_q.w_data, s_q.w_strb);
                pss_pkg::JUNC_OFS:
                    s_d.junc = merge(s_q.junc, s_q.w_data, s_q.w_strb);
                pss_pkg::TEV_ON_OFS:
                    s_d.tev_on = merge(s_q.tev_on, s_q.w_data, s_q.w_strb);
                pss_pkg::NSEG_OFS:
                    s_d.nseg = merge(s_q.nseg, s_q.w_data, s_q.w_strb);
                default:
                begin
                    if (a >= pss_pkg::REF_BASE && ridx < 3'(pss_pkg::NREF)
                        && a < pss_pkg::TGT_BASE)
                        s_d.refs[ridx] = merge(s_q.refs[ridx], s_q.w_data,
                                               s_q.w_strb);
                    else if (a[7:4] == pss_pkg::TGT_BASE[7:4])
                        s_d.tgt[sidx] = merge(s_q.tgt[sidx], s_q.w_data,
                                              s_q.w_strb);
                    else if (a[7:4] == pss_pkg::TIME_BASE[7:4])
                        s_d.tim[sidx] = merge(s_q.tim[sidx], s_q.w_data,
                                              s_q.w_strb);
                    else if (a[7:4] == pss_pkg::RAMP_BASE[7:4])
                        s_d.ramp[sidx] = merge(s_q.ramp[sidx], s_q.w_data,
                                               s_q.w_strb);
                    else
                        s_d.bresp = pss_pkg::RESP_SLVERR;
                end
            endcase
        end

        // read channel: one cycle from address to data
        if (s_q.rvalid && axi_req_i.rready)
            s_d.rvalid = 1'b0;
        if (axi_req_i.arvalid && !s_q.rvalid)
        begin
            a = axi_req_i.araddr;
            ridx = 3'((a - pss_pkg::REF_BASE) >> 2);
            sidx = 2'(a >> 2);
            s_d.rvalid = 1'b1;
            s_d.rresp = pss_pkg::RESP_OKAY;
            s_d.rdata = 32'h0;
            case (a)
                pss_pkg::CTRL_OFS: s_d.rdata[15:0] = s_q.ctrl;
                pss_pkg::STATUS_OFS:
                    s_d.rdata = {s_q.sp, 5'h00, s_q.deviation_pid_group_number, 2'h0, s_q.seg,
                                 s_q.state};
                pss_pkg::START_SP_OFS: s_d.rdata[15:0] = s_q.start_sp;
                pss_pkg::DEV_BAND_OFS: s_d.rdata[15:0] = s_q.dev_band;
                pss_pkg::DEV_GRP_OFS: s_d.rdata[15:0] = s_q.dev_grp;
                pss_pkg::NREF_OFS: s_d.rdata[15:0] = s_q.nref;
                pss_pkg::WAIT_ZONE_OFS: s_d.rdata[15:0] = s_q.wait_zone;
                pss_pkg::WAIT_TIME_OFS: s_d.rdata[15:0] = s_q.wait_time;
                pss_pkg::JUNC_OFS: s_d.rdata[15:0] = s_q.junc;
                pss_pkg::TEV_ON_OFS: s_d.rdata[15:0] = s_q.tev_on;
                pss_pkg::NSEG_OFS: s_d.rdata[15:0] = s_q.nseg;
                default:
                begin
                    if (a >= pss_pkg::REF_BASE && ridx < 3'(pss_pkg::NREF)
                        && a < pss_pkg::TGT_BASE)
                        s_d.rdata[15:0] = s_q.refs[ridx];
                    else if (a[7:4] == pss_pkg::TGT_BASE[7:4])
                        s_d.rdata[15:0] = s_q.tgt[sidx];
                    else if (a[7:4] == pss_pkg::TIME_BASE[7:4])
                        s_d.rdata[15:0] = s_q.tim[sidx];
                    else if (a[7:4] == pss_pkg::RAMP_BASE[7:4])
                        s_d.rdata[15:0] = s_q.ramp[sidx];
                    else
                        s_d.rresp = pss_pkg::RESP_SLVERR;
                end
            endcase
        end

        // zone group: refs assumed ascending, PV on a point goes up
        for (int k = 0; k < pss_pkg::NREF; k++)
            if (16'(k) < s_q.nref && $signed(s_q.pv) >= $signed(s_q.refs[k]))
                zgrp = zgrp + 3'h1;
        dev = adiff(s_q.pv, s_q.sp);
        in_band = dev <= {1'b0, s_q.dev_band};
        case (s_q.ctrl[pss_pkg::CTRL_PIDM_LSB +: 2])
            pss_pkg::PIDM_DEV:
                s_d.deviation_pid_group_number = in_band ? 3'h1 : s_q.dev_grp[2:0];
            pss_pkg::PIDM_BOTH:
                s_d.deviation_pid_group_number = in_band ? zgrp : s_q.dev_grp[2:0];
            default: s_d.deviation_pid_group_number = zgrp;
        endcase

        // program time base, optionally stretched sixty times
        tick_len = s_q.ctrl[pss_pkg::CTRL_TMU_BIT]
            ? TICK_CYCLES * pss_pkg::MIN_PER_HOUR : TICK_CYCLES;
        tick = s_q.tick_cnt >= tick_len - 32'h1;
        s_d.tick_cnt = tick ? 32'h0 : s_q.tick_cnt + 32'h1;
        s_d.tev = s_q.state != pss_pkg::PSS_IDLE && s_q.total >= s_q.tev_on;

        case (s_q.state)
            pss_pkg::PSS_IDLE:
            begin
                s_d.ctrl_out = 16'h0000;
                s_d.events = 8'h00;
                s_d.tev = 1'b0;
                if (s_q.ctrl[pss_pkg::CTRL_RUN_BIT])
                begin
                    s_d.state = pss_pkg::PSS_RUN;
                    s_d.seg = 2'h0;
                    s_d.elapsed = 16'h0000;
                    s_d.total = 16'h0000;
                    s_d.tick_cnt = 32'h0;
                    s_d.ramp_mode = meth;
                    s_d.rate = s_q.ramp[0];
                    s_d.seg_start = s_q.start_sp;
                    if (program_start_selector == pss_pkg::STC_TIME && !meth)
                        s_d.seg_start = s_q.pv;
                    if (program_start_selector == pss_pkg::STC_RAMP)
                    begin
                        s_d.seg_start = s_q.pv;
                        s_d.ramp_mode = 1'b1;
                        if (!meth)
                            s_d.rate = 16'(adiff(s_q.tgt[0], s_q.start_sp)
                                / ((s_q.tim[0] == 16'h0) ? 17'h1
                                   : {1'b0, s_q.tim[0]}));
                    end
                    s_d.sp = s_d.seg_start;
                end
            end
            pss_pkg::PSS_RUN:
            begin
                s_d.ctrl_out = ctrl_calc_i;
                s_d.events = event_calc_i;
                if (tick)
                begin
                    s_d.elapsed = s_q.elapsed + 16'h1;
                    s_d.total = s_q.total + 16'h1;
                    if (s_q.ramp_mode)
                    begin
                        if (adiff(s_q.tgt[s_q.seg], s_q.sp) <= {1'b0, s_q.rate})
                            seg_end = 1'b1;
                        else if ($signed(s_q.tgt[s_q.seg]) > $signed(s_q.sp))
                            s_d.sp = s_q.sp + s_q.rate;
                        else
                            s_d.sp = s_q.sp - s_q.rate;
                    end
                    else if (s_d.elapsed >= s_q.tim[s_q.seg])
                        seg_end = 1'b1;
                    else
                    begin
                        // straight line from segment start to target
                        span = 64'($signed(s_q.tgt[s_q.seg]))
                            - 64'($signed(s_q.seg_start));
                        span = span * $signed(64'(s_d.elapsed))
                            / $signed(64'(s_q.tim[s_q.seg]));
                        s_d.sp = s_q.seg_start + 16'(span);
                    end
                end
                if (seg_end)
                begin
                    nxt = s_q.tgt[s_q.seg];
                    s_d.sp = nxt;
                    if (16'(s_q.seg) + 16'h1 >= s_q.nseg
                        || s_q.seg == 2'(pss_pkg::NSEG - 1))
                        s_d.state = s_q.junc[s_q.seg] ? pss_pkg::PSS_HOLD
                                                      : pss_pkg::PSS_IDLE;
                    else
                    begin
                        s_d.seg = s_q.seg + 2'h1;
                        s_d.seg_start = nxt;
                        s_d.elapsed = 16'h0000;
                        s_d.ramp_mode = meth;
                        s_d.rate = s_q.ramp[s_d.seg];
                        s_d.wait_cnt = 16'h0000;
                        if (s_q.ctrl[pss_pkg::CTRL_WAIT_BIT])
                            s_d.state = pss_pkg::PSS_WAIT;
                    end
                end
            end
            pss_pkg::PSS_WAIT:
            begin
                // segment and event timing stay frozen here
                s_d.ctrl_out = ctrl_calc_i;
                s_d.events = event_calc_i;
                s_d.tev = s_q.tev;
                if (adiff(s_q.pv, s_q.sp) <= {1'b0, s_q.wait_zone})
                    s_d.state = pss_pkg::PSS_RUN;
                else if (tick)
                begin
                    s_d.wait_cnt = s_q.wait_cnt + 16'h1;
                    if (s_d.wait_cnt >= s_q.wait_time)
                        s_d.state = pss_pkg::PSS_RUN;
                end
            end
            pss_pkg::PSS_HOLD:
            begin
                // outputs other than the pid group keep their end-of-program values
                s_d.tev = s_q.tev;
                if (s_q.cn || s_q.ctrl[pss_pkg::CTRL_CANCEL_BIT])
                begin
                    s_d.state = pss_pkg::PSS_IDLE;
                    s_d.ctrl_out = 16'h0000;
                    s_d.events = 8'h00;
                    s_d.tev = 1'b0;
                end
            end
            default: s_d.state = pss_pkg::PSS_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.state <= pss_pkg::PSS_IDLE;
            s_q.ctrl <= pss_pkg::CTRL_RST;
            s_q.nseg <= pss_pkg::NSEG_RST;
            s_q.nref <= pss_pkg::NREF_RST;
            s_q.dev_grp <= pss_pkg::DEV_GRP_RST;
            s_q.deviation_pid_group_number <= 3'h1;
        end
        else
            s_q <= s_d;
    end

    assign axi_rsp_o.awready = !s_q.aw_full && !s_q.bvalid;
    assign axi_rsp_o.wready = !s_q.w_full && !s_q.bvalid;
    assign axi_rsp_o.bvalid = s_q.bvalid;
    assign axi_rsp_o.bresp = s_q.bresp;
    assign axi_rsp_o.arready = !s_q.rvalid;
    assign axi_rsp_o.rvalid = s_q.rvalid;
    assign axi_rsp_o.rdata = s_q.rdata;
    assign axi_rsp_o.rresp = s_q.rresp;
    assign sp_o = s_q.sp;
    assign pid_group_o = s_q.deviation_pid_group_number;
    assign ctrl_out_o = s_q.ctrl_out;
    assign event_o = s_q.events;
    assign time_event_o = s_q.tev;
    assign wait_o = s_q.state == pss_pkg::PSS_WAIT;
endmodule // pss_seq
`default_nettype wire

// ===== verif/pss_seq_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module pss_seq_monitor (
    // clock, reset and bus
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire pss_pkg::pss_axi_req_t axi_req_i,
    input wire pss_pkg::pss_axi_rsp_t axi_rsp_o,
    // pins
    input wire logic [15:0] pv_i,
    input wire logic hold_cancel_i,
    input wire logic [15:0] ctrl_calc_i,
    input wire logic [7:0] event_calc_i,
    input wire logic [15:0] sp_o,
    input wire logic [2:0] pid_group_o,
    input wire logic [15:0] ctrl_out_o,
    input wire logic [7:0] event_o,
    input wire logic time_event_o,
    input wire logic wait_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    a_group_range: assert property (pid_group_o != 3'h0)
        else $error("pid group is zero");
    a_reset_group: assert property (disable iff (1'b0)
        !reset_n_i ##1 !reset_n_i |->
        pid_group_o == 3'h1 && ctrl_out_o == 16'h0)
        else $error("outputs wrong in reset");
    a_wait_sp: assert property (
        wait_o && $past(wait_o) |-> $stable(sp_o))
        else $error("setpoint moved during wait");
    a_wait_tev: assert property (
        wait_o ##1 wait_o |-> $stable(time_event_o))
        else $error("time event moved during wait");
    a_wait_ctrl: assert property (
        wait_o |-> ctrl_out_o == $past(ctrl_calc_i))
        else $error("control output stalled in wait");
    a_wait_event: assert property (
        wait_o |-> event_o == $past(event_calc_i))
        else $error("event output stalled in wait");
    a_cancel_zero: assert property (hold_cancel_i [*3] |->
        ##[1:4] (ctrl_out_o == 16'h0 && event_o == 8'h0))
        else $error("outputs not cleared by cancel");
    // group may only move when its inputs or the settings move
    a_group_steady: assert property (
        (!axi_req_i.wvalid && $stable(pv_i) && $stable(sp_o)) [*8]
        |=> $stable(pid_group_o)) else $error("group changed alone");
endmodule // pss_seq_monitor
`default_nettype wire

// ===== verif/pss_plant.sv
`timescale 1ns/1ns
`default_nettype none
module pss_plant (
    // clock
    input wire logic clock_i,
    // process side
    input wire logic [15:0] pv_set_i,
    input wire logic noisy_i,
    output logic [15:0] pv_o = 16'h0,
    output logic [15:0] ctrl_calc_o = 16'h0,
    output logic [7:0] event_calc_o = 8'h0
);
    integer seed = 32'hd7fb1d2d;
    // pv moves only at an edge so the sync never sees a torn word
    always @(posedge clock_i)
    begin
        pv_o <= pv_set_i;
        ctrl_calc_o <= noisy_i ? 16'($random(seed)) : 16'h1234;
        event_calc_o <= noisy_i ? 8'($random(seed)) : 8'h5a;
    end
endmodule // pss_plant
`default_nettype wire

// ===== verif/pss_seq_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pss_seq_tb;
    localparam logic [33:0] M = 34'h3_ffff_ffff;
    localparam logic [31:0] ZT [14] = '{32'h00_2_0000_1, 32'h00_2_0004_2,
        32'h00_2_0006_2, 32'h00_2_0008_3, 32'h00_2_0064_3, 32'h00_1_0008_2,
        32'h00_1_0003_1, 32'h00_0_0064_1, 32'h40_0_000a_1, 32'h40_0_000b_5,
        32'h40_0_fffd_1, 32'h80_2_0006_2, 32'h80_2_0009_3, 32'h80_2_0014_5};
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic hold_cancel_i = 1'b0;
    logic noisy = 1'b0;
    logic probe = 1'b0;
    logic [15:0] pv_set = 16'h0;
    logic [15:0] pv, ctrl_calc, sp_o, ctrl_out_o;
    logic [7:0] ev_calc, event_o;
    logic [2:0] pid_group_o;
    logic time_event_o, wait_o;
    pss_pkg::pss_axi_req_t rq = '0;
    pss_pkg::pss_axi_rsp_t rs;
    logic [33:0] qe[$], qm[$];
    logic [15:0] pq[$];
    logic [2:0] ps[$];
    int miscompares = 0;
    int check_count = 0;
    int n;
    initial forever #2 clock_i = ~clock_i;
    pss_seq #(.TICK_CYCLES(4)) dut_u (.clock_i(clock_i),
        .reset_n_i(reset_n_i), .axi_req_i(rq), .axi_rsp_o(rs), .pv_i(pv),
        .hold_cancel_i(hold_cancel_i), .ctrl_calc_i(ctrl_calc),
        .event_calc_i(ev_calc), .sp_o(sp_o), .pid_group_o(pid_group_o),
        .ctrl_out_o(ctrl_out_o), .event_o(event_o),
        .time_event_o(time_event_o), .wait_o(wait_o));
    pss_plant plant_u (.clock_i(clock_i), .pv_set_i(pv_set),
        .noisy_i(noisy), .pv_o(pv), .ctrl_calc_o(ctrl_calc),
        .event_calc_o(ev_calc));
    task automatic note(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_rd(input logic [33:0] g, e, m);
        note(g & m, e);
    endtask
    task automatic chk_pt(input logic [15:0] g, e);
        note({18'h0, g}, {18'h0, e});
    endtask
    function automatic logic [15:0] pick(input logic [2:0] s);
        case (s)
            3'h0: return {13'h0, pid_group_o};
            3'h1: return sp_o;
            3'h2: return ctrl_out_o;
            3'h3: return {8'h0, event_o};
            3'h4: return {15'h0, wait_o};
            3'h5: return {15'h0, sp_o < 16'h4};
            3'h6: return {15'h0, sp_o >= 16'hc8 && sp_o <= 16'hd0};
            default: return {15'h0, time_event_o};
        endcase
    endfunction
    always @(posedge clock_i)
    begin
        if (rq.rready && rs.rvalid)
            chk_rd({rs.rresp, rs.rdata}, qe.pop_front(), qm.pop_front());
        if (probe)
            chk_pt(pick(ps.pop_front()), pq.pop_front());
    end
    task automatic pk(input logic [2:0] s, input logic [15:0] e);
        @(posedge clock_i);
        ps.push_back(s);
        pq.push_back(e);
        probe <= 1'b1;
        @(posedge clock_i);
        probe <= 1'b0;
    endtask
    // ready is read mid-cycle, where it equals what the next edge samples
    task automatic hs(input int k);
        logic t;
        do
        begin
            @(negedge clock_i);
            t = k == 0 ? rs.arready : k == 1 ? rs.rvalid : rs.bvalid;
            @(posedge clock_i);
        end while (!t);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic ta, tw;
        @(posedge clock_i);
        ta = 1'b0;
        tw = 1'b0;
        rq.awvalid <= 1'b1;
        rq.wvalid <= 1'b1;
        rq.awaddr <= a;
        rq.wdata <= {16'h0, d};
        rq.bready <= 1'b1;
        while (!(ta && tw))
        begin
            @(negedge clock_i);
            ta = ta | rs.awready;
            tw = tw | rs.wready;
            @(posedge clock_i);
            if (ta) rq.awvalid <= 1'b0;
            if (tw) rq.wvalid <= 1'b0;
        end
        hs(2);
        rq.bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e, m);
        @(posedge clock_i);
        qe.push_back(e);
        qm.push_back(m);
        rq.arvalid <= 1'b1;
        rq.araddr <= a;
        rq.rready <= 1'b1;
        hs(0);
        rq.arvalid <= 1'b0;
        hs(1);
        rq.rready <= 1'b0;
    endtask
    task automatic run(input logic [15:0] c, p, t, input logic [2:0] s,
        input logic [15:0] e, input int w, input logic [33:0] st);
        wr(pss_pkg::TGT_BASE, t);
        pv_set <= p;
        repeat (4) @(posedge clock_i);
        wr(pss_pkg::CTRL_OFS, c | 16'h1);
        repeat (2) @(posedge clock_i);
        pk(s, e);
        repeat (w) @(posedge clock_i);
        rd(pss_pkg::STATUS_OFS, st, 34'hf);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        #100000;
        miscompares++;
        finish_test();
    end
    initial
    begin
        rq.wstrb = 4'hf;
        repeat (20) @(posedge clock_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        rd(pss_pkg::NSEG_OFS, 34'h1, M);
        rd(pss_pkg::DEV_GRP_OFS, 34'h1, M);
        rd(pss_pkg::STATUS_OFS, 34'h101, 34'hffff);
        rd(8'h3c, {2'h2, 32'h0}, M);
        $display("test reset done");
        wr(pss_pkg::REF_BASE, 16'h4);
        wr(pss_pkg::REF_BASE + 8'h4, 16'h8);
        wr(pss_pkg::DEV_BAND_OFS, 16'ha);
        wr(pss_pkg::DEV_GRP_OFS, 16'h5);
        foreach (ZT[i])
        begin
            wr(pss_pkg::CTRL_OFS, {8'h0, ZT[i][31:24]});
            wr(pss_pkg::NREF_OFS, {12'h0, ZT[i][23:20]});
            pv_set <= ZT[i][19:4];
            repeat (8) @(posedge clock_i);
            pk(0, {12'h0, ZT[i][3:0]});
        end
        $display("test zones done");
        wr(pss_pkg::TIME_BASE, 16'h64);
        wr(pss_pkg::RAMP_BASE, 16'h1);
        run(16'h0, 16'h14, 16'h14, 1, 16'h0, 450, 34'h1);
        run(16'h8, 16'h14, 16'h14, 1, 16'h14, 450, 34'h1);
        run(16'h18, 16'h14, 16'h14, 5, 16'h1, 450, 34'h1);
        run(16'h4, 16'hc8, 16'h190, 6, 16'h1, 300, 34'h1);
        $display("test start codes done");
        wr(pss_pkg::TIME_BASE, 16'h4);
        wr(pss_pkg::JUNC_OFS, 16'h1);
        for (int k = 0; k < 2; k++)
        begin
            run(16'h0, 16'h14, 16'h28, 3, 16'h5a, 40, 34'h8);
            noisy <= 1'b1;
            repeat (10) @(posedge clock_i);
            pk(2, 16'h1234);
            pk(3, 16'h5a);
            pk(7, 16'h1);
            hold_cancel_i <= (k == 0);
            if (k == 1) wr(pss_pkg::CTRL_OFS, 16'h2);
            repeat (6) @(posedge clock_i);
            hold_cancel_i <= 1'b0;
            pk(2, 16'h0);
            pk(3, 16'h0);
            pk(7, 16'h0);
            rd(pss_pkg::STATUS_OFS, 34'h1, 34'hf);
            noisy <= 1'b0;
        end
        $display("test hold done");
        wr(pss_pkg::NSEG_OFS, 16'h2);
        wr(pss_pkg::JUNC_OFS, 16'h0);
        wr(pss_pkg::TIME_BASE + 8'h4, 16'h4);
        wr(pss_pkg::TGT_BASE + 8'h4, 16'h28);
        wr(pss_pkg::WAIT_ZONE_OFS, 16'h5);
        wr(pss_pkg::WAIT_TIME_OFS, 16'ha);
        pv_set <= 16'h3e8;
        wr(pss_pkg::CTRL_OFS, 16'h21);
        n = 0;
        while (wait_o !== 1'b1 && n < 200)
        begin
            @(negedge clock_i);
            n++;
        end
        repeat (30) @(posedge clock_i);
        pk(4, 16'h1);
        repeat (20) @(posedge clock_i);
        pk(4, 16'h0);
        $display("test wait done");
        finish_test();
    end
endmodule // pss_seq_tb
bind pss_seq pss_seq_monitor mon_u (.clock_i(clock_i),
    .reset_n_i(reset_n_i), .axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o),
    .pv_i(pv_i), .hold_cancel_i(hold_cancel_i), .ctrl_calc_i(ctrl_calc_i),
    .event_calc_i(event_calc_i), .sp_o(sp_o), .pid_group_o(pid_group_o),
    .ctrl_out_o(ctrl_out_o), .event_o(event_o),
    .time_event_o(time_event_o), .wait_o(wait_o));
`default_nettype wire
